// ---- shared/rtcpi_pkg.sv ----
// Package with register map, field positions and timing constants of the RTC interrupt logic.
`default_nettype none
package rtcpi_pkg;

  // Register offsets on the five-bit address bus.
  localparam logic [4:0] OFF_MAIN_STATUS   = 5'h00;
  localparam logic [4:0] OFF_RT_MODE       = 5'h01;
  localparam logic [4:0] OFF_OUTPUT_CONFIG = 5'h02;
  localparam logic [4:0] OFF_PERIODIC_FLAGS = 5'h03;
  localparam logic [4:0] OFF_PERIODIC_EN   = 5'h03;
  localparam logic [4:0] OFF_ALARM_PF_EN   = 5'h04;

  // Main status field positions.
  localparam int unsigned MS_IRQ_ANY  = 0;
  localparam int unsigned MS_POWER_FAIL_IN_N    = 1;
  localparam int unsigned MS_PERIODIC = 2;
  localparam int unsigned MS_ALARM    = 3;
  localparam int unsigned MS_BLOCK    = 6;
  localparam int unsigned MS_PAGE     = 7;

  // Alarm and power-fail enable register fields.
  localparam int unsigned AP_ALARM_IE = 6;
  localparam int unsigned AP_POWER_FAIL_IN_N_IE = 7;

  // Output configuration fields: a set bit routes that source to the multi-function pin.
  localparam int unsigned OC_POWER_FAIL_IN_N_MFO    = 0;
  localparam int unsigned OC_PERIODIC_MFO = 1;
  localparam int unsigned OC_ALARM_MFO    = 2;

  // Reset values of the writable registers.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Number of periodic flags and of alarm compare bytes.
  localparam int unsigned NUM_PERIODIC = 6;
  localparam int unsigned NUM_CMP      = 6;

  // Crystal choices, two bits in the real-time mode register.
  typedef enum logic [1:0] {
    RTCPI_XTAL_32K,
    RTCPI_XTAL_32K768,
    RTCPI_XTAL_4M9152,
    RTCPI_XTAL_4M194304
  } rtcpi_xtal_e;

  // Crystal frequencies in hertz and the two prescaler targets.
  localparam logic [23:0] HZ_32K       = 24'd32000;
  localparam logic [23:0] HZ_32K768    = 24'd32768;
  localparam logic [23:0] HZ_4M9152    = 24'd4915200;
  localparam logic [23:0] HZ_4M194304  = 24'd4194304;
  localparam logic [23:0] HZ_MID       = 24'd32000;
  localparam logic [23:0] HZ_TICK      = 24'd100;

  // Power-fail debounce: least time in ns and the clock period in ns.
  localparam int unsigned DEB_NS       = 30000;
  localparam int unsigned CLK_NS       = 10;
  localparam int unsigned DEB_CYC_INT  = (DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] DEB_CYCLES   = DEB_CYC_INT[11:0];

  // Interrupt sources that travel together to the pin router.
  typedef struct packed {
    logic alarm;
    logic periodic;
    logic power_fail_in_n;
  } rtcpi_src_s;

  // Host strobes sampled in one cycle.
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } rtcpi_bus_s;

endpackage
`default_nettype wire

// ---- verilog/rtcpi_frac_div.sv ----
// Fractional rate divider: one output pulse per mod_i/inc_i input pulses, exact on average.
`default_nettype none
module rtcpi_frac_div #(
  parameter int unsigned W = 24
) (
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] inc_i,
  input  wire logic [W-1:0] mod_i,
  output var  logic         tick_o
);

  logic [W:0] acc_q;   // Phase accumulator, one bit of headroom.
  logic [W:0] sum;     // Accumulator plus increment.

  // Sum is formed one bit wider so it cannot wrap before the compare.
  assign sum = acc_q + {1'b0, inc_i};

  // Each input pulse advances the phase; passing the modulus emits a tick.
  // A ratio that is not whole gives jitter of one input period but no drift.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      acc_q  <= '0;
      tick_o <= 1'b0;
    end
    else if (en_i && (sum >= {1'b0, mod_i}))
    begin
      acc_q  <= sum - {1'b0, mod_i};
      tick_o <= 1'b1;
    end
    else
    begin
      acc_q  <= en_i ? sum : acc_q;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/rtcpi_top.sv ----
// Prescaler, alarm, periodic and power-fail interrupt logic of the real-time clock.
`default_nettype none
// Summary of operation
// - Prescaler divides crystal to 32 kHz, 100 Hz.
// - Four crystal choices set in mode register.
// - Sources enabled by writing ones to enables.
// - Fixed offsets; status everywhere, others by block.
// - Status bit 0 mirrors either active pin.
// - Status bits 2, 3 hold events; bit 1 follows power fail.
// - Alarm sets status; pin needs alarm enable.
// - Disabled periodic masks status, flags still set.
// - Power-fail bit needs enable; host cannot clear.
// - All enables zero and no pending periodic flag means no pin active.
// - Write one clears status bits 2, 3.
// - Six periodic flags set by their ticks.
// - Any access to flags clears all six.
// - Each periodic tick is a counter rollover.
// - Any enabled periodic tick sets periodic flag.
// - Writing one to periodic flag cancels interrupt.
// - Pending periodic flag survives clearing all enables.
// - Power-fail change held off during chip select.
// - Alarm when all enabled compare bytes match.
// - One enable bit per compare byte.
// - Disabled compare byte always matches.
// - Power-fail flag follows internal signal, self-clears.
// - Power-fail interrupt masked by its enable.
// - Status bits select page and register block.
// - Power-fail input low debounced 30 us.
module rtcpi_top
(
  input  wire logic                   clock_i,
  input  wire logic                   srst_i,
  input  wire logic                   osc_pulse_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   rd_n_i,
  input  wire logic                   wr_n_i,
  input  wire logic [4:0]             addr_i,
  input  wire logic [7:0]             data_i,
  input  wire logic [5:0]             rollover_i,
  input  wire logic [5:0][7:0]        counter_bytes_i,
  input  wire logic [5:0][7:0]        compare_bytes_i,
  input  wire logic                   power_fail_in_n_i,
  output var  logic [7:0]             data_o,
  output var  logic                   data_oe_o,
  output var  logic                   tick_100hz_o,
  output var  logic                   irq_out_pin_n_o,
  output var  logic                   multi_function_out_pin_n_o
);
  import rtcpi_pkg::*;

  rtcpi_bus_s  bus;            // Host strobes gathered for this cycle.
  logic        acc_act;        // A read or write strobe is active with chip select.
  logic        acc_act_q;      // Strobe activity one cycle ago.
  logic        acc_start;      // First cycle of an access.
  logic        rd_start;       // First cycle of a read.
  logic        wr_start;       // First cycle of a write.
  logic [7:0]  main_ctl_q;     // Page and block select bits.
  logic [1:0]  xtal_sel_q;     // Crystal choice.
  logic [7:0]  out_cfg_q;      // Pin routing.
  logic [5:0]  per_en_q;       // Periodic interrupt enables.
  logic [7:0]  ap_en_q;        // Alarm compare enables and the two interrupt enables.
  logic [5:0]  per_flags_q;    // Individual periodic flags.
  logic        per_flag_q;     // Main status periodic flag.
  logic        alarm_flag_q;   // Main status alarm flag.
  logic        pf_flag_q;      // Main status power-fail flag.
  logic        pf_det_q;       // Debounced power-fail level.
  logic        pf_int_q;       // Internal power-fail signal after chip-select gating.
  logic [11:0] deb_cnt_q;      // Debounce counter.
  logic        match_q;        // Alarm match seen at the last 100 Hz tick.
  logic        match;          // All enabled compare bytes equal their counters.
  logic [23:0] xtal_hz;        // Frequency of the selected crystal.
  logic        mid_tick;       // 32 kHz intermediate pulse.
  logic        tick_100;       // 100 Hz pulse from the second stage.
  logic        is_main;        // Address hits the main status register.
  logic        is_pflags;      // Address hits the periodic flags.
  logic        is_blk1;        // Address lies in control block 1 of page 0.
  rtcpi_src_s  src;            // Sources that may drive a pin.
  logic        want_irq_out_pin;      // Some source routed to the interrupt pin is pending.
  logic        want_mfo;       // Some source routed to the multi-function pin is pending.
  logic [7:0]  rdata;          // Read data selected by the address.

  // Strobes are taken as synchronous; an access is acted on once, at its first cycle.
  assign bus       = '{cs: ~cs_n_i, rd: ~rd_n_i, wr: ~wr_n_i, addr: addr_i, wdata: data_i};
  assign acc_act   = bus.cs && (bus.rd || bus.wr);
  assign acc_start = acc_act && !acc_act_q;
  assign rd_start  = acc_start && bus.rd;
  assign wr_start  = acc_start && bus.wr && !bus.rd;

  // Main status decodes on any page and block; the rest live in page 0 only.
  assign is_main   = (bus.addr == OFF_MAIN_STATUS);
  assign is_pflags = !main_ctl_q[MS_PAGE] && !main_ctl_q[MS_BLOCK]
                     && (bus.addr == OFF_PERIODIC_FLAGS);
  assign is_blk1   = !main_ctl_q[MS_PAGE] && main_ctl_q[MS_BLOCK];

  // Edge tracker for the access strobes.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      acc_act_q <= 1'b0;
    else
      acc_act_q <= acc_act;
  end

  // Crystal frequency table feeding the first divider stage.
  always_comb
  begin
    case (rtcpi_xtal_e'(xtal_sel_q))
      RTCPI_XTAL_32K:      xtal_hz = HZ_32K;
      RTCPI_XTAL_32K768:   xtal_hz = HZ_32K768;
      RTCPI_XTAL_4M9152:   xtal_hz = HZ_4M9152;
      RTCPI_XTAL_4M194304: xtal_hz = HZ_4M194304;
      default:             xtal_hz = HZ_32K;
    endcase
  end

  // First stage brings any crystal down to 32 kHz.
  rtcpi_frac_div #(.W(24)) u_stage_mid (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .en_i    (osc_pulse_i),
    .inc_i   (HZ_MID),
    .mod_i   (xtal_hz),
    .tick_o  (mid_tick)
  );

  // Second stage divides 32 kHz to the 100 Hz counter-chain tick.
  rtcpi_frac_div #(.W(24)) u_stage_tick (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .en_i    (mid_tick),
    .inc_i   (HZ_TICK),
    .mod_i   (HZ_MID),
    .tick_o  (tick_100)
  );

  // The tick leaves through a flop so the counter chain sees a clean pulse.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      tick_100hz_o <= 1'b0;
    else
      tick_100hz_o <= tick_100;
  end

  // Control registers written by the host.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      main_ctl_q <= RST_BYTE;
      xtal_sel_q <= 2'h0;
      out_cfg_q  <= RST_BYTE;
      per_en_q   <= 6'h00;
      ap_en_q    <= RST_BYTE;
    end
    else if (wr_start)
    begin
      // Only the select bits of main status are storage; flags are handled below.
      if (is_main)
      begin
        main_ctl_q[MS_PAGE]  <= bus.wdata[MS_PAGE];
        main_ctl_q[MS_BLOCK] <= bus.wdata[MS_BLOCK];
      end
      else if (is_blk1)
      begin
        case (bus.addr)
          OFF_RT_MODE:       xtal_sel_q <= bus.wdata[1:0];
          OFF_OUTPUT_CONFIG: out_cfg_q  <= bus.wdata;
          OFF_PERIODIC_EN:   per_en_q   <= bus.wdata[5:0];
          OFF_ALARM_PF_EN:   ap_en_q    <= bus.wdata;
          default:           ap_en_q    <= ap_en_q;
        endcase
      end
    end
  end

  // Individual periodic flags: a rollover sets, any access clears, and the set wins.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      per_flags_q <= 6'h00;
    else if (acc_start && is_pflags)
      per_flags_q <= rollover_i;
    else
      per_flags_q <= per_flags_q | rollover_i;
  end

  // Main periodic flag: only enabled rollovers set it, a written one clears it.
  // Clearing every enable leaves a pending flag in place until it is written.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      per_flag_q <= 1'b0;
    else if (|(rollover_i & per_en_q))
      per_flag_q <= 1'b1;
    else if (wr_start && is_main && bus.wdata[MS_PERIODIC])
      per_flag_q <= 1'b0;
  end

  // Each clear enable bit relaxes one byte comparator to always equal.
  always_comb
  begin
    match = 1'b1;
    for (int i = 0; i < NUM_CMP; i++)
    begin
      if (ap_en_q[i] && (counter_bytes_i[i] != compare_bytes_i[i]))
        match = 1'b0;
    end
  end

  // Compare is judged at each 100 Hz tick; with no byte enabled no alarm is possible.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      match_q <= 1'b0;
    else if (tick_100hz_o)
      match_q <= match && (|ap_en_q[5:0]);
  end

  // Alarm flag sets on the first tick of a match, whatever the alarm enable.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      alarm_flag_q <= 1'b0;
    else if (tick_100hz_o && match && (|ap_en_q[5:0]) && !match_q)
      alarm_flag_q <= 1'b1;
    else if (wr_start && is_main && bus.wdata[MS_ALARM])
      alarm_flag_q <= 1'b0;
  end

  // Debounce: the pin must stay at a new level for the full interval to be believed.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      deb_cnt_q <= 12'h000;
      pf_det_q  <= 1'b0;
    end
    else if (power_fail_in_n_i == !pf_det_q)
      deb_cnt_q <= 12'h000;
    else if (deb_cnt_q == DEB_CYCLES - 12'h001)
    begin
      deb_cnt_q <= 12'h000;
      pf_det_q  <= !power_fail_in_n_i;
    end
    else
      deb_cnt_q <= deb_cnt_q + 12'h001;
  end

  // A change is held off while chip select is active so a cycle is never cut short.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      pf_int_q <= 1'b0;
    else if (!bus.cs)
      pf_int_q <= pf_det_q;
  end

  // Power-fail flag follows the internal signal while enabled; the host cannot clear it.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      pf_flag_q <= 1'b0;
    else if (!pf_int_q)
      pf_flag_q <= 1'b0;
    else if (ap_en_q[AP_POWER_FAIL_IN_N_IE])
      pf_flag_q <= 1'b1;
  end

  // Sources gated by their enables; the periodic flag needs no gate once pending.
  assign src.power_fail_in_n    = pf_flag_q && ap_en_q[AP_POWER_FAIL_IN_N_IE];
  assign src.alarm    = alarm_flag_q && ap_en_q[AP_ALARM_IE];
  assign src.periodic = per_flag_q;
  assign want_mfo  = (src.power_fail_in_n && out_cfg_q[OC_POWER_FAIL_IN_N_MFO])
                  || (src.periodic && out_cfg_q[OC_PERIODIC_MFO])
                  || (src.alarm && out_cfg_q[OC_ALARM_MFO]);
  assign want_irq_out_pin = (src.power_fail_in_n && !out_cfg_q[OC_POWER_FAIL_IN_N_MFO])
                  || (src.periodic && !out_cfg_q[OC_PERIODIC_MFO])
                  || (src.alarm && !out_cfg_q[OC_ALARM_MFO]);

  // Pins are levels that hold while a routed source pends; both are active low.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      irq_out_pin_n_o            <= 1'b1;
      multi_function_out_pin_n_o <= 1'b1;
    end
    else
    begin
      irq_out_pin_n_o            <= !want_irq_out_pin;
      multi_function_out_pin_n_o <= !want_mfo;
    end
  end

  // Read multiplexer; unmapped locations read zero.
  always_comb
  begin
    rdata = 8'h00;
    if (is_main)
    begin
      rdata[MS_IRQ_ANY]  = !irq_out_pin_n_o || !multi_function_out_pin_n_o;
      rdata[MS_POWER_FAIL_IN_N]    = pf_flag_q;
      rdata[MS_PERIODIC] = per_flag_q;
      rdata[MS_ALARM]    = alarm_flag_q;
      rdata[MS_BLOCK]    = main_ctl_q[MS_BLOCK];
      rdata[MS_PAGE]     = main_ctl_q[MS_PAGE];
    end
    else if (is_pflags)
      rdata = {2'b00, per_flags_q};
    else if (is_blk1)
    begin
      case (bus.addr)
        OFF_RT_MODE:       rdata = {6'h00, xtal_sel_q};
        OFF_OUTPUT_CONFIG: rdata = out_cfg_q;
        OFF_PERIODIC_EN:   rdata = {2'b00, per_en_q};
        OFF_ALARM_PF_EN:   rdata = ap_en_q;
        default:           rdata = 8'h00;
      endcase
    end
  end

  // Read data is caught once at the start of a read and driven while the read lasts.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end
    else
    begin
      data_oe_o <= bus.cs && bus.rd;
      if (rd_start)
        data_o <= rdata;
    end
  end

  // Properties watching the block's own outputs and state.
  property p_d0_mirrors_pins;
    @(posedge clock_i) disable iff (srst_i)
      rd_start && is_main |=> data_o[MS_IRQ_ANY] == (!$past(irq_out_pin_n_o)
                                                    || !$past(multi_function_out_pin_n_o));
  endproperty
  a_d0_mirrors_pins: assert property (p_d0_mirrors_pins)
    else $error("status bit 0 does not mirror the pins");

  property p_pflags_cleared;
    @(posedge clock_i) disable iff (srst_i)
      acc_start && is_pflags && rollover_i == 6'h00 |=> per_flags_q == 6'h00;
  endproperty
  a_pflags_cleared: assert property (p_pflags_cleared)
    else $error("periodic flags not cleared by access");

  property p_flags_set_always;
    @(posedge clock_i) disable iff (srst_i)
      rollover_i[0] |=> per_flags_q[0];
  endproperty
  a_flags_set_always: assert property (p_flags_set_always)
    else $error("periodic flag missed a rollover");

  property p_enabled_tick_sets;
    @(posedge clock_i) disable iff (srst_i)
      |(rollover_i & per_en_q) |=> per_flag_q ##1 !irq_out_pin_n_o || out_cfg_q[OC_PERIODIC_MFO];
  endproperty
  a_enabled_tick_sets: assert property (p_enabled_tick_sets)
    else $error("enabled rollover did not raise the interrupt");

  property p_masked_periodic;
    @(posedge clock_i) disable iff (srst_i)
      !per_flag_q && per_en_q == 6'h00 |=> !per_flag_q;
  endproperty
  a_masked_periodic: assert property (p_masked_periodic)
    else $error("periodic status set while all enables are clear");

  property p_w1c_periodic;
    @(posedge clock_i) disable iff (srst_i)
      wr_start && is_main && bus.wdata[MS_PERIODIC] && !(|(rollover_i & per_en_q))
      |=> !per_flag_q;
  endproperty
  a_w1c_periodic: assert property (p_w1c_periodic)
    else $error("periodic flag not cleared by a written one");

  property p_pf_needs_enable;
    @(posedge clock_i) disable iff (srst_i)
      $rose(pf_flag_q) |-> $past(ap_en_q[AP_POWER_FAIL_IN_N_IE]) && $past(pf_int_q);
  endproperty
  a_pf_needs_enable: assert property (p_pf_needs_enable)
    else $error("power-fail flag set without enable or event");

  property p_pf_restore;
    @(posedge clock_i) disable iff (srst_i)
      !pf_int_q |=> !pf_flag_q;
  endproperty
  a_pf_restore: assert property (p_pf_restore)
    else $error("power-fail flag outlived restored power");

  property p_pf_gated_cs;
    @(posedge clock_i) disable iff (srst_i)
      bus.cs |=> $stable(pf_int_q);
  endproperty
  a_pf_gated_cs: assert property (p_pf_gated_cs)
    else $error("internal power-fail changed during chip select");

  property p_quiet_when_disabled;
    @(posedge clock_i) disable iff (srst_i)
      ap_en_q[7:6] == 2'b00 && !per_flag_q |=> irq_out_pin_n_o && multi_function_out_pin_n_o;
  endproperty
  a_quiet_when_disabled: assert property (p_quiet_when_disabled)
    else $error("pin active with every enable clear");

  c_alarm_irq: cover property (@(posedge clock_i) disable iff (srst_i)
                               $rose(alarm_flag_q) ##1 !irq_out_pin_n_o);
  c_pflags_read: cover property (@(posedge clock_i) disable iff (srst_i)
                                 rd_start && is_pflags && per_flags_q != 6'h00);
  c_pf_event: cover property (@(posedge clock_i) disable iff (srst_i) $rose(pf_flag_q));

endmodule
`default_nettype wire

// ---- tb/rtcpi_host_model.sv ----
// Host processor model on the parallel byte bus.
`default_nettype none
module rtcpi_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       cs_n_o,
  output var  logic       rd_n_o,
  output var  logic       wr_n_o,
  output var  logic [4:0] addr_o,
  output var  logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus; released lines show the inverse of the last value.
  initial
  begin
    {cs_n_o, rd_n_o, wr_n_o, addr_o, wdata_o} = {3'h7, 13'h0};
  end
  // Write: enables and clears take effect only where a one is written.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i) #1;
    {cs_n_o, wr_n_o, addr_o, wdata_o} = {2'b00, a, d};
    repeat (2) @(posedge clock_i);
    #1;
    {cs_n_o, wr_n_o, addr_o, wdata_o} = {2'b11, ~a, ~d};
  endtask
  // Read: data is taken one cycle after the strobe is first seen.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock_i) #1;
    {cs_n_o, rd_n_o, addr_o} = {2'b00, a};
    repeat (2) @(posedge clock_i);
    #1;
    d = rdata_i;
    {cs_n_o, rd_n_o, addr_o} = {2'b11, ~a};
  endtask
  // Chip select alone, with no strobe, held for n clocks.
  task automatic sel(input int n);
    @(posedge clock_i) #1;
    cs_n_o = 1'b0;
    repeat (n) @(posedge clock_i);
    #1;
    cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- tb/rtc_prescaler_interrupt_logic_tb_top.sv ----
// Self-checking bench of the interrupt logic.
`default_nettype none
module rtc_prescaler_interrupt_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock_i = 0;
  logic              srst_i = 1;
  logic              cs_n, rd_n, wr_n, oe, tick, irq_n, mfo_n;
  logic              pf_n = 1;
  logic [4:0]        addr;
  logic [7:0]        wdat, rdat, d;
  logic [5:0]        roll = 0;
  logic [5:0][7:0]   cnt = '0;
  logic [5:0][7:0]   cmp = {40'h7777777777, 8'h15};
  int                n_fail = 0;
  int                n_tests = 0;
  int                t;
  always #5 clock_i = ~clock_i;
  rtcpi_top dut_u (.clock_i(clock_i), .srst_i(srst_i), .osc_pulse_i(1'b1), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .data_i(wdat), .rollover_i(roll),
    .counter_bytes_i(cnt), .compare_bytes_i(cmp), .power_fail_in_n_i(pf_n),
    .data_o(rdat), .data_oe_o(oe), .tick_100hz_o(tick), .irq_out_pin_n_o(irq_n),
    .multi_function_out_pin_n_o(mfo_n));
  rtcpi_host_model host_u (.clock_i(clock_i), .rdata_i(rdat), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdat));
  // Compares one byte and counts it.
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  // Reads a register and compares it.
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk("reg", e, d);
    chk("oe", 8'h01, {7'h0, oe});
    @(posedge clock_i) #1;
    chk("oe", 8'h00, {7'h0, oe});
  endtask
  // Pins as {irq, mfo}, active low.
  task automatic pins(input logic [1:0] e);
    chk("pins", {6'h0, e}, {6'h0, irq_n, mfo_n});
  endtask
  // Selects a control register block, writing zero to the clearable bits.
  task automatic blk(input logic b);
    host_u.wr(5'h00, {1'b0, b, 6'h00});
  endtask
  // One-cycle rollover pulse.
  task automatic pulse(input logic [5:0] r);
    @(posedge clock_i) #1 roll = r;
    @(posedge clock_i) #1 roll = 6'h00;
  endtask
  // Waits for a tick; a missing tick counts as a mismatch.
  task automatic wtick();
    for (t = 0; t < 700 && tick !== 1'b1; t++)
      @(posedge clock_i) #1;
    chk("tick", 8'h01, {7'h0, tick});
  endtask
  // Periodic flags with and without the periodic interrupt.
  task automatic t_periodic();
    pulse(6'h20);
    rdc(5'h00, 8'h00);
    pins(2'b11);
    rdc(5'h03, 8'h20);
    rdc(5'h03, 8'h00);
    blk(1'b1);
    host_u.wr(5'h03, 8'h02);
    blk(1'b0);
    pulse(6'h02);
    rdc(5'h00, 8'h05);
    blk(1'b1);
    host_u.wr(5'h03, 8'h00);
    blk(1'b0);
    rdc(5'h00, 8'h05);
    pins(2'b01);
    host_u.wr(5'h00, 8'h04);
    rdc(5'h00, 8'h00);
    pins(2'b11);
  endtask
  // Tick spacing, then alarm with one compare byte enabled.
  task automatic t_alarm();
    wtick();
    repeat (319) @(posedge clock_i) #1;
    chk("tick", 8'h00, {7'h0, tick});
    @(posedge clock_i) #1;
    chk("tick", 8'h01, {7'h0, tick});
    blk(1'b1);
    host_u.wr(5'h04, 8'h01);
    cnt[0] = 8'h15;
    wtick();
    repeat (3) @(posedge clock_i);
    rdc(5'h00, 8'h48);
    pins(2'b11);
    host_u.wr(5'h04, 8'h41);
    pins(2'b01);
    host_u.wr(5'h00, 8'h48);
    rdc(5'h00, 8'h40);
    pins(2'b11);
  endtask
  // Power fail routed to the second pin, masked, then restored.
  task automatic t_power_fail_in_n();
    host_u.wr(5'h02, 8'h01);
    host_u.wr(5'h04, 8'h80);
    pf_n = 1'b0;
    // The debounce ends while chip select is held, so the flag must wait for its release.
    repeat (2990) @(posedge clock_i);
    host_u.sel(40);
    pins(2'b11);
    host_u.wr(5'h00, 8'h42);
    rdc(5'h00, 8'h43);
    pins(2'b10);
    host_u.wr(5'h04, 8'h00);
    rdc(5'h00, 8'h42);
    pf_n = 1'b1;
    repeat (3100) @(posedge clock_i);
    rdc(5'h00, 8'h40);
  endtask
  // Crystal 32.768 kHz: 8000 intermediate pulses fill a whole number of accumulator
  // cycles, so 25 ticks must span exactly 8192 clocks whatever the starting phase.
  task automatic t_xtal();
    int n;
    int k;
    host_u.wr(5'h01, 8'h01);
    repeat (2) @(posedge clock_i) #1;
    wtick();
    n = 0;
    k = 0;
    while (k < 25 && n < 9000)
    begin
      @(posedge clock_i) #1;
      n++;
      if (tick === 1'b1)
        k++;
    end
    chk("span_hi", 8'h20, n[15:8]);
    chk("span_lo", 8'h00, n[7:0]);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cuts a hang well beyond the expected 15600 cycles.
  initial
  begin
    #500000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge clock_i);
    #1 srst_i = 0;
    rdc(5'h00, 8'h00);
    pins(2'b11);
    t_periodic();
    t_alarm();
    t_power_fail_in_n();
    t_xtal();
    end_of_test();
  end
endmodule
`default_nettype wire
